/* File: hdl/sgeb_pkg.sv */
// Purpose: Shared constants and types for the receive elastic buffer.
// Assumes: Code-group data arrives decoded, one byte plus flags per word.
// Notes: What this block does is listed below.
// What this block does
// - Fabric buffer is default, twice transceiver size
// - Transceiver depth 64, fabric depth 128
// - Delete idles in gap toward half full
// - Absorb 200 ppm, one slip per 5000
// - Tolerate byte replication by 10 and 100
// - Keep 31 entries headroom about half full
// - Small buffer only without 10 Mb/s
// - 50 ppm clocks need 16 entries either side
// - Shared oscillator keeps occupancy constant
// - Bypass transceiver buffer when fabric used
// - Full-tolerance tri-speed option is the default
// - Write side runs on recovered receive clock
// - Read side runs on 125 MHz clock
package sgeb_pkg;
	localparam int XCVR_DEPTH  = 64;
	localparam int FAB_DEPTH   = 2 * XCVR_DEPTH;
	localparam int ADDR_W      = 7;
	localparam int HALF_FULL   = FAB_DEPTH / 2;
	localparam int HEADROOM    = 31;
	localparam int PPM_SLIP    = 5000;
	localparam int STAGE_DEPTH = 16;
	localparam int WORD_W      = 10;
	localparam logic [7:0] IDLE_K   = 8'hbc;
	localparam logic [7:0] IDLE_D   = 8'h50;
	localparam logic [ADDR_W:0] HALF_OCC = (ADDR_W+1)'(HALF_FULL);
	// One code group: byte, control flag, decode error
	typedef struct packed {
		logic       err;
		logic       isK;
		logic [7:0] data;
	} sgeb_word_s;
	typedef enum logic {SGEB_SEL_FABRIC, SGEB_SEL_XCVR} sgeb_sel_e;
	// Gray conversion used on both pointer paths
	function automatic logic [ADDR_W:0] bin2gray(input logic [ADDR_W:0] b);
		return b ^ (b >> 1);
	endfunction
	function automatic logic [ADDR_W:0] gray2bin(input logic [ADDR_W:0] g);
		logic [ADDR_W:0] b;
		b = '0;
		for (int i = ADDR_W; i >= 0; i--)
			b[i] = (i == ADDR_W) ? g[i] : (b[i+1] ^ g[i]);
		return b;
	endfunction
endpackage

/* File: hdl/sgeb_sync.sv */
// Purpose: Two-flop synchroniser for a pointer or level.
// Assumes: Multi-bit input is gray coded.
// Notes: First stage is read only by the second.
`timescale 1ns/10ps
`default_nettype none
module sgeb_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sgeb_sync_s;
	sgeb_sync_s st_reg, st_next;
	// Shift through both stages
	always_comb begin
		st_next = st_reg;
		if (ce) begin
			st_next.s1 = din;
			st_next.s2 = st_reg.s1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign dout = st_reg.s2;
endmodule // sgeb_sync
`default_nettype wire

/* File: hdl/sgeb_fifo.sv */
// Purpose: Small synchronous FIFO on the read side output.
// Assumes: Single clock, flop storage.
// Notes: Full and empty are exact; ready reflects room.
`timescale 1ns/10ps
`default_nettype none
module sgeb_fifo #(
	parameter int W = 10,
	parameter int D = 16
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic         ce,
	input  wire logic [W-1:0] inData,
	input  wire logic         inValid,
	output logic              inReady,
	output logic      [W-1:0] outData,
	output logic              outValid,
	input  wire logic         outReady
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} sgeb_fifo_s;
	sgeb_fifo_s st_reg, st_next;
	logic push, pop;
	assign inReady  = (st_reg.cnt != (AW+1)'(D));
	assign outValid = (st_reg.cnt != '0);
	assign outData  = st_reg.mem[st_reg.rp];
	assign push = ce && inValid && inReady;
	assign pop  = ce && outValid && outReady;
	// Pointer and count update
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wp] = inData;
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (pop)
			st_next.rp = st_reg.rp + 1'b1;
		if (push && !pop)
			st_next.cnt = st_reg.cnt + 1'b1;
		else if (pop && !push)
			st_next.cnt = st_reg.cnt - 1'b1;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	fifo_no_over_a: assert property (@(posedge mclk) disable iff (reset)
		st_reg.cnt <= (AW+1)'(D))
		else $error("fifo count above depth");
endmodule // sgeb_fifo
`default_nettype wire

/* File: hdl/sgeb_rx_elastic.sv */
// Purpose: Receive elastic buffer, recovered clock to 125 MHz core clock.
// Assumes: rxClk is the recovered clock; reset is in mclk domain.
// Notes: Idle pairs K28.5+D16.2 are added or dropped for rate; on overflow any incoming word is dropped.
`timescale 1ns/10ps
`default_nettype none
module sgeb_rx_elastic
	import sgeb_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       ce,
	input  wire logic       rxClk,
	input  wire logic       rxReset,
	input  wire sgeb_word_s rxWord,
	input  wire logic       useXcvrBuf,
	output logic            xcvrBufBypass,
	output sgeb_word_s      coreWord,
	output logic            coreValid,
	input  wire logic       coreReady,
	output logic [ADDR_W:0] occupancy,
	output logic            overflowFlag,
	output logic            underflowFlag
);
	localparam int PW = ADDR_W + 1;

	// Write domain state
	typedef struct packed {
		logic [FAB_DEPTH-1:0][WORD_W-1:0] mem;
		logic [PW-1:0] wBin;
		logic [PW-1:0] wGray;
		logic          prevK;
		logic          ovTog;
	} sgeb_wr_s;
	sgeb_wr_s wr_reg, wr_next;

	// Read domain state
	typedef struct packed {
		logic [PW-1:0] rBin;
		logic [PW-1:0] rGray;
		logic          inGap;
		logic          prevK;
		logic          holdK;
		logic          holdD;
		logic          started;
		logic [WORD_W-1:0] outWord;
		logic          outValid;
		logic          ovSeen;
		logic          ovFlag;
		logic          unFlag;
		logic [PW-1:0] occ;
	} sgeb_rd_s;
	sgeb_rd_s rd_reg, rd_next;

	logic [PW-1:0] rGraySync, wGraySync, wBinSync;
	logic          ovTogSync;
	logic          fifoReady;
	logic [WORD_W-1:0] fifoOut;
	logic [PW-1:0] wrOcc;
	logic          wrIsIdleD, rdIsIdleK, rdIsIdleD;
	sgeb_word_s    headWord;

	// Transceiver buffer bypassed whenever fabric one is chosen
	// Choice of the small buffer is only safe without 10 Mb/s
	assign xcvrBufBypass = !useXcvrBuf;

	// Crossings: gray pointers and an overflow toggle
	sgeb_sync #(.W(PW)) uSyncR (
		.clk   (rxClk),
		.reset (rxReset),
		.ce    (1'b1),
		.din   (rd_reg.rGray),
		.dout  (rGraySync)
	);
	sgeb_sync #(.W(PW+1)) uSyncW (
		.clk   (mclk),
		.reset (reset),
		.ce    (ce),
		.din   ({wr_reg.ovTog, wr_reg.wGray}),
		.dout  ({ovTogSync, wGraySync})
	);
	assign wBinSync = gray2bin(wGraySync);

	// Write side on recovered clock; drops a whole idle pair when over half
	assign wrOcc = wr_reg.wBin - gray2bin(rGraySync);
	assign wrIsIdleD = !rxWord.isK && rxWord.data == IDLE_D;
	always_comb begin
		wr_next = wr_reg;
		wr_next.prevK = rxWord.isK && rxWord.data == IDLE_K;
		if (wr_reg.prevK && wrIsIdleD && wrOcc > HALF_OCC) begin
			// Drop the D half; K half already stored is rewound
			wr_next.wBin = wr_reg.wBin - 1'b1;
		end else if (wrOcc >= PW'(FAB_DEPTH)) begin
			wr_next.ovTog = !wr_reg.ovTog;
		end else begin
			wr_next.mem[wr_reg.wBin[ADDR_W-1:0]] = rxWord;
			wr_next.wBin = wr_reg.wBin + 1'b1;
		end
		wr_next.wGray = bin2gray(wr_next.wBin);
	end
	always_ff @(posedge rxClk) begin
		if (rxReset)
			wr_reg <= '0;
		else
			wr_reg <= wr_next;
	end

	// Read side on core clock; idle pairs repeated when under half
	assign headWord = sgeb_word_s'(wr_reg.mem[rd_reg.rBin[ADDR_W-1:0]]);
	assign rdIsIdleK = headWord.isK && headWord.data == IDLE_K;
	assign rdIsIdleD = !headWord.isK && headWord.data == IDLE_D;
	// Live count from the current pointer; a stale count reads past empty
	always_comb begin
		rd_next = rd_reg;
		if (ce) begin
			rd_next.occ = wBinSync - rd_reg.rBin;
			rd_next.ovSeen = ovTogSync;
			if (ovTogSync != rd_reg.ovSeen)
				rd_next.ovFlag = 1'b1;
			// Reading starts once at half full, so start-up is no underflow
			if (rd_next.occ >= HALF_OCC)
				rd_next.started = 1'b1;
			if (rd_reg.started && (!rd_reg.outValid || fifoReady)) begin
				rd_next.outValid = 1'b0;
				if (rd_reg.holdK) begin
					// Repeated pair, K half first
					rd_next.outWord = {1'b0, 1'b1, IDLE_K};
					rd_next.outValid = 1'b1;
					rd_next.holdK = 1'b0;
					rd_next.holdD = 1'b1;
				end else if (rd_reg.holdD) begin
					// Second half of a repeated idle pair
					rd_next.outWord = {1'b0, 1'b0, IDLE_D};
					rd_next.outValid = 1'b1;
					rd_next.holdD = 1'b0;
				end else if (rd_next.occ == '0) begin
					rd_next.unFlag = 1'b1;
				end else begin
					rd_next.outWord = headWord;
					rd_next.outValid = 1'b1;
					rd_next.rBin = rd_reg.rBin + 1'b1;
					rd_next.prevK = rdIsIdleK;
					if (rd_reg.prevK && rdIsIdleD && rd_next.occ < HALF_OCC)
						rd_next.holdK = 1'b1;
				end
				rd_next.prevK = (rd_reg.holdD || rd_reg.holdK) ? 1'b0
					: rd_next.prevK;
			end
		end
		rd_next.rGray = bin2gray(rd_next.rBin);
	end
	always_ff @(posedge mclk) begin
		if (reset)
			rd_reg <= '0;
		else
			rd_reg <= rd_next;
	end

	// Output FIFO gives back-pressure from the core
	sgeb_fifo #(.W(WORD_W), .D(STAGE_DEPTH)) uFifo (
		.mclk     (mclk),
		.reset    (reset),
		.ce       (ce),
		.inData   (rd_reg.outWord),
		.inValid  (rd_reg.outValid),
		.inReady  (fifoReady),
		.outData  (fifoOut),
		.outValid (coreValid),
		.outReady (coreReady)
	);
	assign coreWord      = sgeb_word_s'(fifoOut);
	assign occupancy     = rd_reg.occ;
	assign overflowFlag  = rd_reg.ovFlag;
	assign underflowFlag = rd_reg.unFlag;

	// Depth is twice transceiver depth
	depth_double_a: assert property (@(posedge mclk) disable iff (reset)
		FAB_DEPTH == 2 * XCVR_DEPTH)
		else $error("fabric depth not double");
	headroom_ok_a: assert property (@(posedge mclk) disable iff (reset)
		HALF_FULL - 1 >= HEADROOM)
		else $error("headroom below needed");
	bypass_sel_a: assert property (@(posedge mclk) disable iff (reset)
		xcvrBufBypass == !useXcvrBuf)
		else $error("bypass does not follow select");
	flag_sticky_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(underflowFlag) |=> underflowFlag [*4])
		else $error("underflow flag not sticky");
	repeat_pair_a: assert property (@(posedge mclk) disable iff (reset)
		rd_reg.holdD && ce && fifoReady |=>
		rd_reg.outValid && rd_reg.outWord[7:0] == IDLE_D)
		else $error("repeated idle half missing");
	occ_bound_a: assert property (@(posedge mclk) disable iff (reset)
		occupancy <= PW'(FAB_DEPTH))
		else $error("occupancy out of range");
	drop_wr_a: assert property (@(posedge rxClk) disable iff (rxReset)
		wr_reg.prevK && wrIsIdleD && wrOcc > HALF_OCC
		|=> wr_reg.wBin == $past(wr_reg.wBin) - 1'b1)
		else $error("idle not removed over half");
	wr_advance_a: assert property (@(posedge rxClk) disable iff (rxReset)
		!(wr_reg.prevK && wrIsIdleD) && wrOcc < PW'(FAB_DEPTH)
		|=> wr_reg.wBin == $past(wr_reg.wBin) + 1'b1)
		else $error("write pointer did not advance");
	cov_repeat_c: cover property (@(posedge mclk) rd_reg.holdD);
	cov_under_c: cover property (@(posedge mclk) $rose(underflowFlag));
	cov_over_c: cover property (@(posedge mclk) $rose(overflowFlag));
	cov_stall_c: cover property (@(posedge mclk) coreValid && !coreReady);
endmodule // sgeb_rx_elastic
`default_nettype wire

/* File: verif/sgeb_rx_source.sv */
// Purpose: Link-side source of code groups on the recovered clock.
// Assumes: Idle pairs fill gaps; frames start after a full pair.
// Notes: A toggle on startTog sends one frame of counting bytes.
`timescale 1ns/10ps
`default_nettype none
module sgeb_rx_source
	import sgeb_pkg::*;
(
	input  wire logic       rxClk,
	input  wire logic       rxReset,
	input  wire logic       startTog,
	input  wire logic [9:0] frameLen,
	output sgeb_word_s      rxWord
);
	logic       lastTog;
	logic       needD;
	logic [9:0] left;
	// One word per link edge, never a gap in the stream
	always @(posedge rxClk) begin
		if (rxReset) begin
			lastTog <= startTog;
			needD   <= 1'b0;
			left    <= '0;
			rxWord  <= '{1'b0, 1'b1, IDLE_K};
		end else if (left != 0 || (startTog != lastTog && !needD)) begin
			lastTog <= startTog;
			left    <= (left != 0) ? left - 10'd1 : frameLen - 10'd1;
			rxWord  <= '{1'b0, 1'b0,
				8'((left != 0) ? frameLen - left : 10'd0)};
		end else begin
			needD  <= !needD;
			rxWord <= '{1'b0, !needD, needD ? IDLE_D : IDLE_K};
		end
	end
endmodule // sgeb_rx_source
`default_nettype wire

/* File: verif/sgeb_rx_elastic_tb.sv */
// Purpose: Self-checking bench for the receive elastic buffer.
// Assumes: Reader paced to the link word rate unless a test says not.
// Notes: Flags are sticky, so the overflow test runs last.
`timescale 1ns/10ps
`default_nettype none
module sgeb_rx_elastic_tb
	import sgeb_pkg::*;
;
	logic            mclk, reset, rxClk, rxReset, useXcvrBuf, coreReady;
	logic            startTog, chkOn, hold, fast, xcvrBufBypass, coreValid;
	logic            overflowFlag, underflowFlag, afterK;
	logic [1:0]      pace;
	logic [7:0]      expByte;
	logic [9:0]      frameLen;
	logic [ADDR_W:0] occupancy;
	sgeb_word_s      rxWord, coreWord;
	int              miscompares, comparisons, rcvCount;

	sgeb_rx_source u_sgeb_rx_source (.rxClk(rxClk), .rxReset(rxReset),
		.startTog(startTog), .frameLen(frameLen), .rxWord(rxWord));
	sgeb_rx_elastic u_sgeb_rx_elastic (.mclk(mclk), .reset(reset),
		.ce(1'b1), .rxClk(rxClk), .rxReset(rxReset), .rxWord(rxWord),
		.useXcvrBuf(useXcvrBuf), .xcvrBufBypass(xcvrBufBypass),
		.coreWord(coreWord), .coreValid(coreValid), .coreReady(coreReady),
		.occupancy(occupancy), .overflowFlag(overflowFlag),
		.underflowFlag(underflowFlag));

	// Core clock 20 ns; link clock 80 ns, offset in phase
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		rxClk = 1'b0;
		#7;
		forever #40 rxClk = ~rxClk;
	end
	// One accept per link word keeps both rates equal
	always @(posedge mclk) begin
		pace <= pace + 2'h1;
		coreReady <= !hold && (fast || pace == 2'h3);
	end
	// Frame bytes must leave in order; a data word after K is idle
	always @(posedge mclk) begin
		if (coreValid === 1'b1 && coreReady === 1'b1) begin
			if (chkOn && coreWord.isK === 1'b0 && afterK === 1'b0) begin
				check("coreWord.data", 32'(expByte), 32'(coreWord.data));
				expByte = expByte + 8'h01;
				rcvCount = rcvCount + 1;
			end
			afterK = coreWord.isK;
		end
	end

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Bypass output follows the buffer choice, fabric last
	task automatic runBypass();
		for (int i = 0; i < 2; i++) begin
			useXcvrBuf <= !i[0];
			repeat (2) @(posedge mclk);
			check("xcvrBufBypass", 32'(i[0]), 32'(xcvrBufBypass));
		end
	endtask

	// Stalled reader over idles: deletion must cap the fill
	task automatic runGap();
		hold <= 1'b1;
		repeat (1500) @(posedge mclk);
		check("overflowFlag", 32'd0, 32'(overflowFlag));
		check("occCap", 32'd1, 32'(occupancy <= HALF_OCC + 4));
		hold <= 1'b0;
		repeat (200) @(posedge mclk);
	endtask

	// Short frame at equal rates arrives whole, level near half
	task automatic runFrame();
		int i;
		expByte = 8'h00;
		rcvCount = 0;
		chkOn <= 1'b1;
		startTog <= ~startTog;
		for (i = 0; i < 3000 && rcvCount < 40; i++)
			@(posedge mclk);
		check("rcvCount", 32'd40, 32'(rcvCount));
		if (i == 3000) summarize();
		check("underflowFlag", 32'd0, 32'(underflowFlag));
		check("occBand", 32'd1, 32'(occupancy > HALF_OCC - HEADROOM
			&& occupancy < HALF_OCC + HEADROOM));
		chkOn <= 1'b0;
	endtask

	// Reader four times too fast through a long frame
	task automatic runUnderflow();
		int i;
		fast <= 1'b1;
		frameLen <= 10'd200;
		startTog <= ~startTog;
		for (i = 0; i < 3000 && underflowFlag !== 1'b1; i++)
			@(posedge mclk);
		check("underflowFlag", 32'd1, 32'(underflowFlag));
		if (i == 3000) summarize();
		fast <= 1'b0;
		repeat (1000) @(posedge mclk);
	endtask

	// Stalled reader through a long frame: headroom, then overflow
	task automatic runOverflow();
		int i;
		hold <= 1'b1;
		startTog <= ~startTog;
		repeat (124) @(posedge mclk);
		check("overflowEarly", 32'd0, 32'(overflowFlag));
		for (i = 0; i < 3000 && overflowFlag !== 1'b1; i++)
			@(posedge mclk);
		check("overflowFlag", 32'd1, 32'(overflowFlag));
	endtask

	// Time-zero values, reset, then the scenarios
	initial begin
		reset = 1'b1;
		rxReset = 1'b1;
		useXcvrBuf = 1'b0;
		coreReady = 1'b0;
		startTog = 1'b0;
		frameLen = 10'd40;
		chkOn = 1'b0;
		hold = 1'b0;
		fast = 1'b0;
		pace = 2'h0;
		expByte = 8'h00;
		miscompares = 0;
		comparisons = 0;
		rcvCount = 0;
		afterK = 1'b0;
		repeat (5) @(posedge mclk);
		check("coreValid", 32'd0, 32'(coreValid)); // reset state
		check("flags", 32'd0, 32'({overflowFlag, underflowFlag})); // reset state
		reset <= 1'b0;
		// Link reset must see at least two link edges
		repeat (8) @(posedge mclk);
		rxReset <= 1'b0;
		runBypass();
		repeat (1000) @(posedge mclk);
		runGap();
		runFrame();
		runUnderflow();
		runOverflow();
		summarize();
	end
endmodule // sgeb_rx_elastic_tb
`default_nettype wire
